// ---- sio_pkg.sv ----
package sio_pkg;

  // Register bus widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets, one aligned word each.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0c;
  localparam logic [7:0] OFF_INT_CLR = 8'h10;
  localparam logic [7:0] OFF_INT_EN = 8'h14;

  // Field positions in the control word.
  localparam int START_BIT = 7;
  localparam int ABORT_BIT = 6;
  localparam int MODE_LSB = 4;
  localparam int CLKSEL_LSB = 0;

  // Field positions in the status word.
  localparam int ACTIVE_BIT = 3;
  localparam int SHIFTING_BIT = 2;

  // Interrupt event positions.
  localparam int EV_BYTE = 0;
  localparam int EV_END = 1;
  localparam int EV_W = 2;

  // Transfer mode codes.
  localparam logic [1:0] MODE_TX = 2'h0;
  localparam logic [1:0] MODE_TXRX = 2'h2;
  localparam logic [1:0] MODE_RX = 2'h3;

  // Clock select code for the external clock.
  localparam logic [2:0] SCK_EXTERNAL = 3'h7;

  // Internal half period is this count shifted left by the clock select.
  localparam logic [9:0] HALF_BASE = 10'h002;

  // The last bit index of a byte.
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Values after reset.
  localparam logic [7:0] DBR_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = MODE_TX;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;

  // Control word held by the engine.
  typedef struct packed {
    logic start;
    logic [1:0] mode;
    logic [2:0] clksel;
  } ctrl_s;

  // Engine states.
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_WAIT} state_e;

endpackage

// ---- sio_in_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser for pins that arrive from outside the clock's domain.
module sio_in_sync #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // First stage, read only by the second stage.
  logic [WIDTH-1:0] meta_r;

  // Both stages reset high, the idle level of the serial lines.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_r <= '1;
      o_sync <= '1;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // sio_in_sync
`default_nettype wire

// ---- sio_shift_receive_transceive.sv ----
`timescale 1ns/1ns
`default_nettype none
// Clocked serial shift engine for receive and exchange transfers.
module sio_shift_receive_transceive #(
  parameter int DIV_W = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [sio_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sio_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [sio_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_pin_oe,
  input wire logic i_serial_input_pin,
  output logic o_serial_output_pin,
  output logic o_serial_buffer_interrupt
);
  import sio_pkg::*;

  // The slowest internal half period must fit the divider; refused while the design is built.
  if (DIV_W < 8)
  begin : g_div_check
    $error("DIV_W too small for the slowest internal clock");
  end

  ctrl_s ctrl_r; // Start, mode and clock select.
  state_e state_r; // Engine state.
  logic [7:0] dbr_r; // Shared data buffer.
  logic [7:0] rx_shift_r; // Receive shift register.
  logic [7:0] tx_shift_r; // Transmit shift register.
  logic [3:0] bit_cnt_r; // Bits received in this byte.
  logic [DIV_W-1:0] div_cnt_r; // Internal clock divider.
  logic active_r; // Transfer-active flag.
  logic need_read_r; // Received byte not yet read.
  logic need_write_r; // Next outgoing byte not yet written.
  logic sck_int_r; // Internal serial clock level.
  logic sck_prev_r; // Synchronised clock one cycle back.
  logic so_r; // Serial output level.
  logic sck_oe_r; // Clock pin drive enable.
  logic irq_r; // Interrupt output.
  logic [EV_W-1:0] int_stat_r; // Sticky event bits.
  logic [EV_W-1:0] int_en_r; // Event enables.
  logic [DATA_W-1:0] rdata_r; // Read data, one cycle after the strobe.

  // Synchronised pins.
  logic [1:0] pins_sync;
  logic sck_sync;
  logic si_sync;

  sio_in_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_serial_clock_pin, i_serial_input_pin}),
    .o_sync(pins_sync)
  );

  assign sck_sync = pins_sync[1];
  assign si_sync = pins_sync[0];

  // Address decode.
  wire sel_ctrl = (i_addr == OFF_CTRL);
  wire sel_data = (i_addr == OFF_DATA);
  wire wr_ctrl = i_wr && sel_ctrl;
  wire wr_data = i_wr && sel_data;
  wire rd_data = i_rd && sel_data;
  wire wr_clr = i_wr && (i_addr == OFF_INT_CLR);
  wire wr_en = i_wr && (i_addr == OFF_INT_EN);

  // Mode and clock decode.
  wire ext_clk = (ctrl_r.clksel == SCK_EXTERNAL);
  wire is_txrx = (ctrl_r.mode == MODE_TXRX);
  wire mode_ok = (ctrl_r.mode == MODE_TXRX) || (ctrl_r.mode == MODE_RX);
  wire [1:0] wr_mode = i_wdata[MODE_LSB +: 2];
  wire mode_change = wr_ctrl && (wr_mode != ctrl_r.mode);

  // Commands carried by a control write; abort is a one-shot and reads back as zero.
  wire abort_cmd = wr_ctrl && i_wdata[ABORT_BIT];
  wire start_cmd = wr_ctrl && i_wdata[START_BIT] && !i_wdata[ABORT_BIT] && (state_r == ST_IDLE) && mode_ok;

  // Internal half period doubles with each step of the clock select.
  wire [DIV_W-1:0] half_cnt = DIV_W'(HALF_BASE << ctrl_r.clksel);
  wire shifting = (state_r == ST_SHIFT);
  wire div_tick = shifting && !ext_clk && (div_cnt_r == half_cnt - DIV_W'(1));

  // Edges of the shift clock; external edges come from the synchronised pin.
  wire ext_fall = sck_prev_r && !sck_sync;
  wire ext_rise = !sck_prev_r && sck_sync;
  wire fall_evt = shifting && (ext_clk ? ext_fall : (div_tick && sck_int_r));
  wire rise_evt = shifting && (ext_clk ? ext_rise : (div_tick && !sck_int_r));
  wire byte_done = rise_evt && (bit_cnt_r == LAST_BIT);

  // A waiting engine may go on once the buffer has been serviced.
  wire serviced = !need_read_r && (!is_txrx || !need_write_r);
  wire resume = (state_r == ST_WAIT) && serviced && ctrl_r.start;
  wire wait_stop = (state_r == ST_WAIT) && !ctrl_r.start;

  // Next received byte and next outgoing bit; the first bit of a byte comes from the buffer.
  wire [7:0] rx_next = {si_sync, rx_shift_r[7:1]};
  wire [7:0] tx_src = (bit_cnt_r == 4'h0) ? dbr_r : tx_shift_r;

  // Transfer end events drop the active flag.
  wire finish = (byte_done && !ctrl_r.start) || wait_stop;
  wire end_evt = active_r && (finish || abort_cmd);
  wire [EV_W-1:0] events = {end_evt, byte_done};

  // Read data selection.
  logic [DATA_W-1:0] rdata_nxt;
  always_comb
  begin
    rdata_nxt = '0;
    unique case (i_addr)
      OFF_CTRL: rdata_nxt[7:0] = {ctrl_r.start, 1'b0, ctrl_r.mode, 1'b0, ctrl_r.clksel};
      OFF_DATA: rdata_nxt[7:0] = dbr_r;
      OFF_STATUS: rdata_nxt[ACTIVE_BIT:SHIFTING_BIT] = {active_r, shifting};
      OFF_INT_STAT: rdata_nxt[EV_W-1:0] = int_stat_r;
      OFF_INT_EN: rdata_nxt[EV_W-1:0] = int_en_r;
      default: rdata_nxt = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      rdata_r <= '0;
    else
      rdata_r <= i_rd ? rdata_nxt : '0;
  end

  // Control word; abort also withdraws the start request.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      ctrl_r <= '{start: 1'b0, mode: MODE_RESET, clksel: CLKSEL_RESET};
    else if (abort_cmd)
      ctrl_r.start <= 1'b0;
    else if (wr_ctrl)
    begin
      ctrl_r.start <= i_wdata[START_BIT];
      // Mode and clock may only change while nothing is moving.
      if (state_r == ST_IDLE)
      begin
        ctrl_r.mode <= wr_mode;
        ctrl_r.clksel <= i_wdata[CLKSEL_LSB +: 3];
      end
    end
  end

  // Engine state machine.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      state_r <= ST_IDLE;
    else if (abort_cmd)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (start_cmd)
            state_r <= ST_SHIFT;
        ST_SHIFT:
          if (byte_done)
          begin
            // The external clock never waits; the internal one stalls for service.
            if (!ctrl_r.start)
              state_r <= ST_IDLE;
            else if (!ext_clk)
              state_r <= ST_WAIT;
          end
        ST_WAIT:
          if (wait_stop)
            state_r <= ST_IDLE;
          else if (resume)
            state_r <= ST_SHIFT;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Transfer-active flag: set by start, cleared by finish or abort.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      active_r <= 1'b0;
    else if (start_cmd)
      active_r <= 1'b1;
    else if (abort_cmd || finish)
      active_r <= 1'b0;
  end

  // Internal clock divider; the clock rests high outside shifting.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || !shifting || ext_clk)
    begin
      div_cnt_r <= '0;
      sck_int_r <= 1'b1;
    end
    else if (div_tick)
    begin
      div_cnt_r <= '0;
      sck_int_r <= !sck_int_r;
    end
    else
      div_cnt_r <= div_cnt_r + DIV_W'(1);
  end

  // Clock pin drive and edge history.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sck_prev_r <= 1'b1;
      sck_oe_r <= 1'b0;
    end
    else
    begin
      sck_prev_r <= sck_sync;
      sck_oe_r <= !ext_clk;
    end
  end

  // Receive path: sample on the rising edge, LSB first.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || start_cmd || abort_cmd)
    begin
      rx_shift_r <= '0;
      bit_cnt_r <= '0;
    end
    else if (rise_evt)
    begin
      rx_shift_r <= rx_next;
      bit_cnt_r <= byte_done ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  // Transmit path: drive on the falling edge; otherwise the last bit stands.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      tx_shift_r <= '0;
      so_r <= 1'b1;
    end
    else if (fall_evt && is_txrx)
    begin
      so_r <= tx_src[0];
      tx_shift_r <= {1'b0, tx_src[7:1]};
    end
  end

  // Shared buffer; a received byte wins over a software write in the same cycle.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      dbr_r <= DBR_RESET;
    else if (byte_done)
      dbr_r <= rx_next;
    else if (mode_change && (state_r == ST_IDLE))
      dbr_r <= DBR_RESET;
    else if (wr_data)
      dbr_r <= i_wdata[7:0];
  end

  // Service flags; the hardware set wins over the software clear.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || start_cmd || abort_cmd)
    begin
      need_read_r <= 1'b0;
      need_write_r <= 1'b0;
    end
    else
    begin
      need_read_r <= byte_done || (need_read_r && !rd_data);
      need_write_r <= (byte_done && is_txrx) || (need_write_r && !wr_data);
    end
  end

  // Interrupt status, enable and output.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      int_stat_r <= '0;
      int_en_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      int_stat_r <= events | (int_stat_r & ~(wr_clr ? i_wdata[EV_W-1:0] : '0));
      if (wr_en)
        int_en_r <= i_wdata[EV_W-1:0];
      irq_r <= |(int_stat_r & int_en_r);
    end
  end

  assign o_rdata = rdata_r;
  assign o_serial_clock_pin = sck_int_r;
  assign o_serial_clock_pin_oe = sck_oe_r;
  assign o_serial_output_pin = so_r;
  assign o_serial_buffer_interrupt = irq_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // A finished byte lands in the buffer in LSB-first order.
  rx_lsb_first_a: assert property (byte_done |=> dbr_r == $past(rx_next))
    else $error("received byte not loaded into buffer");

  // Each finished byte raises the buffer event.
  byte_event_a: assert property (byte_done |=> int_stat_r[EV_BYTE])
    else $error("buffer event missing after byte");

  // In the wait state the internal clock stands high.
  wait_clock_held_a: assert property ((state_r == ST_WAIT) |-> sck_int_r && !rise_evt)
    else $error("clock moved during wait");

  // An external clock never enters the wait state.
  ext_no_stall_a: assert property (ext_clk && byte_done && ctrl_r.start && !abort_cmd |=> state_r == ST_SHIFT)
    else $error("external clock transfer stalled");

  // Clearing start ends the transfer right after the byte.
  stop_finish_a: assert property (byte_done && !ctrl_r.start && !abort_cmd |=> !active_r && state_r == ST_IDLE)
    else $error("transfer did not end after last byte");

  // Abort drops the active flag at once.
  abort_now_a: assert property (abort_cmd |=> !active_r && state_r == ST_IDLE)
    else $error("abort did not stop transfer");

  // The output bit changes only on a falling edge.
  so_hold_a: assert property (!fall_evt |=> $stable(so_r))
    else $error("serial output changed without falling edge");

  // A falling edge in exchange mode drives the next bit.
  fall_drive_a: assert property (fall_evt && is_txrx |=> so_r == $past(tx_src[0]))
    else $error("wrong bit driven on falling edge");

  // Exchange waits until the next byte is written.
  exch_wait_a: assert property ((state_r == ST_WAIT) && need_write_r && !abort_cmd |=> state_r != ST_SHIFT)
    else $error("exchange resumed without new byte");

  // Start raises the active flag.
  start_active_a: assert property (start_cmd |=> active_r)
    else $error("active flag not set by start");

endmodule // sio_shift_receive_transceive
`default_nettype wire

// ---- sio_peer.sv ----
`timescale 1ns/1ns
`default_nettype none
// Far-side serial peer: sends its byte LSB first on falling edges and takes the device's bits on rising edges.
module sio_peer (
  input wire logic i_sck_dev,
  input wire logic i_sck_oe,
  input wire logic i_so,
  input wire logic [7:0] i_tx,
  input wire logic i_go,
  input wire logic i_sync,
  output logic o_sck,
  output logic o_si,
  output logic [7:0] o_rx
);
  logic ext = 1'b1; // The external clock rests high between frames.
  logic [7:0] sh = 8'h00; // Outgoing byte, shifted right.
  int n = 0; // Bit position within the byte.
  assign o_sck = i_sck_oe ? i_sck_dev : ext; // Level on the shared clock wire.
  initial o_si = 1'b0;
  initial o_rx = 8'h00;
  // One frame of eight pulses at 800 ns per trigger; the clock stands still otherwise.
  always @(posedge i_go)
  begin
    repeat (8)
    begin
      #400 ext = 1'b0;
      #400 ext = 1'b1;
    end
  end
  // A new bit goes out on each falling edge; the byte is taken at the first one.
  always @(negedge o_sck)
  begin
    if (n == 0) sh = i_tx;
    o_si = sh[0];
    sh = sh >> 1;
  end
  // The device's bit is taken on rising edges; after the byte the data line stops holding.
  always @(posedge o_sck)
  begin
    o_rx = {i_so, o_rx[7:1]};
    n = (n + 1) % 8;
    if (n == 0) o_si <= #600 ~o_si;
  end
  // Realigns the bit count after an aborted byte.
  always @(posedge i_sync) n = 0;
endmodule // sio_peer
`default_nettype wire

// ---- sio_shift_receive_transceive_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench: register master, serial peer and random bytes.
module sio_shift_receive_transceive_tb_top;
  import sio_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic go = 1'b0;
  logic sync_p = 1'b0;
  logic [7:0] peer_tx = 8'h00;
  logic last_bit = 1'b1; // The serial output leaves reset high.
  logic [31:0] rdata;
  logic [31:0] d;
  logic [7:0] peer_rx;
  logic sck, sck_oe, pin_sck, si, so, irq;
  logic [7:0] regs [6] = '{OFF_CTRL, OFF_DATA, OFF_STATUS, OFF_INT_STAT, OFF_INT_EN, 8'h3c};
  logic [1:0] modes [2] = '{MODE_TXRX, MODE_RX};
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #50 clk = ~clk; // 10 MHz system clock.
  sio_shift_receive_transceive dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .i_serial_clock_pin(pin_sck), .o_serial_clock_pin(sck),
    .o_serial_clock_pin_oe(sck_oe), .i_serial_input_pin(si), .o_serial_output_pin(so),
    .o_serial_buffer_interrupt(irq));
  sio_peer peer (.i_sck_dev(sck), .i_sck_oe(sck_oe), .i_so(so), .i_tx(peer_tx), .i_go(go), .i_sync(sync_p),
    .o_sck(pin_sck), .o_si(si), .o_rx(peer_rx));
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // A hung wait is cut short here and counted as a mismatch.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One write cycle; the strobe drops for a cycle so back-to-back calls never collide.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  // One read cycle; the data is taken in the single cycle where it stands.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  function automatic logic [31:0] cw(input logic s, input logic a, input logic [1:0] m, input logic [2:0] c);
    cw = (32'(s) << START_BIT) | (32'(a) << ABORT_BIT) | (32'(m) << MODE_LSB) | (32'(c) << CLKSEL_LSB);
  endfunction
  // One transfer of nb bytes; start is cleared during the last byte so it ends by itself.
  task automatic xfer(input logic [1:0] m, input logic [2:0] cs, input int nb);
    logic [7:0] tx;
    logic [7:0] rx;
    logic hi;
    for (int i = 0; i < nb; i++)
    begin
      tx = 8'($urandom);
      rx = 8'($urandom);
      peer_tx = rx;
      // The mode is chosen before the byte is written, because a mode change empties the buffer.
      if (i == 0) wr(OFF_CTRL, cw(1'b0, 1'b0, m, cs));
      if (m == MODE_TXRX) wr(OFF_DATA, {24'h0, tx});
      if (i == 0)
      begin
        wr(OFF_CTRL, cw(1'b1, 1'b0, m, cs));
        chk("so before first fall", so, last_bit);
        chk("clock drive", sck_oe, cs != SCK_EXTERNAL);
      end
      if (i == nb - 1) wr(OFF_CTRL, cw(1'b0, 1'b0, m, cs));
      if (cs == SCK_EXTERNAL)
      begin
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
      end
      while (irq !== 1'b1) @(posedge clk);
      hi = 1'b1;
      repeat (30)
      begin
        @(posedge clk);
        hi = hi & sck;
      end
      chk("clock held in wait", hi, 1'b1);
      wr(OFF_INT_EN, 32'h0);
      #1 chk("irq masked", irq, 1'b0);
      @(posedge clk);
      wr(OFF_INT_EN, 32'h3);
      #1 chk("irq enabled", irq, 1'b1);
      @(posedge clk);
      wr(OFF_INT_CLR, 32'h1);
      rd(OFF_DATA, d);
      chk("received byte", d, {24'h0, rx});
      if (m == MODE_TXRX) chk("sent byte", peer_rx, tx);
      if (m == MODE_TXRX) last_bit = tx[7];
    end
    rd(OFF_STATUS, d);
    chk("active after end", d, 32'h0);
    repeat (20) @(posedge clk);
    chk("last bit held", so, last_bit);
    wr(OFF_INT_CLR, 32'h3);
    $display("transfer mode %0d clock %0d done", m, cs);
  endtask
  // Main sequence: reset values, exchange transfers at clock selects 1 and 2, receive transfers at clock select 2 and external, refusal and aborts.
  initial
  begin
    void'($urandom(32'hf3e8b0e7));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // The clock wire settles from unknown to high early on, which the peer counts as a bit.
    sync_p <= 1'b1;
    @(posedge clk);
    sync_p <= 1'b0;
    foreach (regs[k])
    begin
      rd(regs[k], d);
      chk("reset value", d, 32'h0);
    end
    chk("so after reset", so, 1'b1);
    $display("reset values done");
    wr(OFF_INT_EN, 32'h3);
    xfer(MODE_TXRX, 3'h1, 2);
    xfer(MODE_TXRX, 3'h2, 1);
    xfer(MODE_RX, 3'h2, 2);
    xfer(MODE_RX, SCK_EXTERNAL, 2);
    wr(OFF_CTRL, cw(1'b0, 1'b0, MODE_TX, 3'h0));
    wr(OFF_CTRL, cw(1'b1, 1'b0, MODE_TX, 3'h0));
    rd(OFF_STATUS, d);
    chk("start in transmit mode", d, 32'h0);
    $display("transmit mode refusal done");
    foreach (modes[k])
    begin
      peer_tx = 8'($urandom);
      wr(OFF_CTRL, cw(1'b0, 1'b0, modes[k], 3'h2));
      rd(OFF_DATA, d);
      chk("buffer after mode change", d, 32'h0);
      wr(OFF_DATA, {24'h0, 8'($urandom)});
      wr(OFF_CTRL, cw(1'b1, 1'b0, modes[k], 3'h2));
      rd(OFF_STATUS, d);
      chk("active after start", d[ACTIVE_BIT], 1'b1);
      repeat (40) @(posedge clk);
      wr(OFF_CTRL, cw(1'b0, 1'b1, modes[k], 3'h2));
      rd(OFF_STATUS, d);
      chk("active after abort", d, 32'h0);
      repeat (150) @(posedge clk);
      rd(OFF_INT_STAT, d);
      chk("no byte after abort", d[EV_BYTE], 1'b0);
      chk("clock stopped", sck, 1'b1);
      sync_p <= 1'b1;
      wr(OFF_INT_CLR, 32'h3);
      sync_p <= 1'b0;
      $display("abort mode %0d done", modes[k]);
    end
    conclude();
  end
endmodule // sio_shift_receive_transceive_tb_top
`default_nettype wire
